// ==== common/rdim_pkg.sv ====
// Purpose: Constants for the report driven two-wire master
// Assumes: 64-byte reports arrive as a byte stream, report id first
// Notes: Timing counts derive from the 200 MHz system clock
package rdim_pkg;
  localparam int REPORT_LEN = 64;
  localparam logic [7:0] ID_ENABLE = 8'h01;
  localparam logic [7:0] ID_WRITE = 8'h02;
  localparam logic [7:0] ID_READ = 8'h03;
  localparam logic [7:0] EN_ON = 8'h01;
  localparam logic [7:0] EN_OFF = 8'h00;
  localparam int POS_FLAGS = 1;
  localparam int POS_TMO = 3;
  localparam int BIT_START = 7;
  localparam int BIT_STOP = 6;
  localparam int BIT_ERR = 7;
  localparam int WR_MAX = 6;
  localparam int RD_MAX = 62;
  localparam int EP_REPLY = 2;
  localparam int IF_SPECIAL = 1;
  localparam int CLK_MHZ = 200;
  localparam int TMO_STEP_US = 500;
  localparam int TMO_STEP_CYC = TMO_STEP_US * CLK_MHZ;
  localparam int TMO_ZERO_STEPS = 256;
  localparam int BUS_KHZ = 100;
  localparam int QUARTER_CYC = (CLK_MHZ * 1000) / (BUS_KHZ * 4);
endpackage

// ==== hdl/rdim_master.sv ====
// Purpose: Two-wire bus master steered by 64-byte special-function reports
// Assumes: Report bytes stream in on hostClk; replies stream out on hostClk
// Notes: Bus engine runs on ref_clk; reports cross by toggle handshake
//
// Behaviour
// - Every report in either direction is exactly 64 bytes, id byte first.
// - Commands arrive on interface 1 endpoint 2; replies leave on endpoint 2.
// - Enable report id 1: byte 1 value 01 enables, 00 disables, others reserved.
// - Enabled: drive pins high, ignore port writes; disabled: return pins, high (here the pins then follow portWrite).
// - Flags byte of enable report ignored; no pull-up or protocol options.
// - Timeout byte gives stretch limit in 500 us steps; zero means 256.
// - Stretch beyond timeout is reported as an error like a missing ack; only bit and ack slots check it, start and stop stall without limit.
// - Write id 2: bit7 start, bit6 stop, bits 2..0 data count.
// - Start flag gives start condition before the first data byte.
// - Stop flag gives stop condition after last valid data byte.
// - Write count zero to six; larger counts discard the report silently.
// - Each write accepted while enabled with count up to six is answered with an ack report: error bit7, count 2..0.
// - Ack count is last byte accepted; error set on any missing ack.
// - Read issues start before command and stop after final byte.
// - Read data returns in one report id 3: error bit7, count 5..0.
// - Missing ack on the command byte sets error and aborts the read.
// - During the read data phase only a stretch timeout is reported as an error.
`timescale 1ns/1ps
`default_nettype none
module rdim_master (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hostClk,
  input wire logic hostRstn,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic [7:0] txByte,
  output logic txValid,
  input wire logic txReady,
  input wire logic [1:0] portWrite,
  output logic masterOn,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  typedef enum logic [11:0] {
    RDIM_IDLE = 12'h001, RDIM_START = 12'h002, RDIM_BIT = 12'h004,
    RDIM_ACK = 12'h008, RDIM_NEXT = 12'h010, RDIM_STOP = 12'h020,
    RDIM_REPLY = 12'h040, RDIM_RBIT = 12'h080, RDIM_RACK = 12'h100,
    RDIM_WAIT = 12'h200, RDIM_SEND = 12'h400, RDIM_DONE = 12'h800
  } rdim_state_type;

  // Host side: collect one report, pulse handshake toggle to the bus domain
  logic [7:0] rep_q [0:rdim_pkg::REPORT_LEN-1];
  logic [5:0] rxIdx_q;
  logic reqTgl_q;
  logic [7:0] out_q [0:rdim_pkg::REPORT_LEN-1];
  logic [5:0] txIdx_q;
  logic txBusy_q;

  always_ff @(posedge hostClk) begin
    if (!hostRstn) begin
      rxIdx_q <= 6'h00;
      reqTgl_q <= 1'b0;
    end else if (rxValid) begin
      rep_q[rxIdx_q] <= rxByte;
      rxIdx_q <= rxIdx_q + 6'h01;
      if (rxIdx_q == 6'h3f)
        reqTgl_q <= ~reqTgl_q;
    end
  end

  // Reply crossing back; no ack toggle returns, so the reply buffer is not held for the host
  logic rspTgl_q;
  logic rsp_s1_q, rsp_s2_q, rsp_s3_q;
  always_ff @(posedge hostClk) begin
    if (!hostRstn) begin
      rsp_s1_q <= 1'b0;
      rsp_s2_q <= 1'b0;
      rsp_s3_q <= 1'b0;
      txIdx_q <= 6'h00;
      txBusy_q <= 1'b0;
    end else begin
      rsp_s1_q <= rspTgl_q;
      rsp_s2_q <= rsp_s1_q;
      rsp_s3_q <= rsp_s2_q;
      if (rsp_s2_q != rsp_s3_q)
        txBusy_q <= 1'b1;
      else if (txBusy_q && txReady) begin
        txIdx_q <= txIdx_q + 6'h01;
        if (txIdx_q == 6'h3f)
          txBusy_q <= 1'b0;
      end
    end
  end
  assign txValid = txBusy_q;
  assign txByte = out_q[txIdx_q];

  // Bus domain: detect a new report
  logic req_s1_q, req_s2_q, req_s3_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= reqTgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end
  wire newRep = req_s2_q != req_s3_q;

  // Bus pins sampled through three stages
  logic [2:0] sclSy_q, sdaSy_q;
  logic sclLvl_q, sdaLvl_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclSy_q <= 3'h7;
      sdaSy_q <= 3'h7;
      sclLvl_q <= 1'b1;
      sdaLvl_q <= 1'b1;
    end else begin
      sclSy_q <= {sclSy_q[1:0], sclIn};
      sdaSy_q <= {sdaSy_q[1:0], sdaIn};
      if (sclSy_q[1] == sclSy_q[2])
        sclLvl_q <= sclSy_q[2];
      if (sdaSy_q[1] == sdaSy_q[2])
        sdaLvl_q <= sdaSy_q[2];
    end
  end

  rdim_state_type st_q;
  logic on_q;
  logic [7:0] tmoSteps_q;
  logic [1:0] phase_q;
  logic [15:0] qcnt_q;
  logic [24:0] stretch_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [5:0] idx_q, cnt_q, done_q;
  logic isRead_q, cmdPhase_q, doStop_q, err_q, sclDrv_q, sdaDrv_q;
  logic [7:0] rd_q [0:rdim_pkg::RD_MAX-1];

  wire [8:0] steps = (tmoSteps_q == 8'h00) ? 9'(rdim_pkg::TMO_ZERO_STEPS) : {1'b0, tmoSteps_q};
  wire [24:0] tmoLimit = 25'(steps * rdim_pkg::TMO_STEP_CYC);
  wire tick = qcnt_q == 16'(rdim_pkg::QUARTER_CYC - 1);
  wire stretched = sclDrv_q && !sclLvl_q;

  // Quarter-bit timer halts while a slave stretches the clock
  always_ff @(posedge ref_clk) begin
    if (!rstn || tick || st_q == RDIM_IDLE)
      qcnt_q <= 16'h0000;
    else if (!stretched)
      qcnt_q <= qcnt_q + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || !stretched)
      stretch_q <= 25'h0000000;
    else
      stretch_q <= stretch_q + 25'h0000001;
  end
  wire stretchOut = stretch_q >= tmoLimit;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q <= RDIM_IDLE;
      on_q <= 1'b0;
      tmoSteps_q <= 8'h00;
      phase_q <= 2'h0;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      idx_q <= 6'h00;
      cnt_q <= 6'h00;
      done_q <= 6'h00;
      isRead_q <= 1'b0;
      cmdPhase_q <= 1'b0;
      doStop_q <= 1'b0;
      err_q <= 1'b0;
      sclDrv_q <= 1'b1;
      sdaDrv_q <= 1'b1;
      rspTgl_q <= 1'b0;
    end else begin
      case (st_q)
        RDIM_IDLE: begin
          phase_q <= 2'h0;
          if (newRep) begin
            err_q <= 1'b0;
            done_q <= 6'h00;
            idx_q <= 6'h02;
            if (rep_q[0] == rdim_pkg::ID_ENABLE) begin
              // Flags byte deliberately unused
              if (rep_q[1] == rdim_pkg::EN_ON) begin
                on_q <= 1'b1;
                tmoSteps_q <= rep_q[rdim_pkg::POS_TMO];
              end else if (rep_q[1] == rdim_pkg::EN_OFF)
                on_q <= 1'b0;
              sclDrv_q <= 1'b1;
              sdaDrv_q <= 1'b1;
            end else if (on_q && rep_q[0] == rdim_pkg::ID_WRITE) begin
              if ({3'h0, rep_q[1][2:0]} <= 6'(rdim_pkg::WR_MAX)) begin
                isRead_q <= 1'b0;
                cnt_q <= {3'h0, rep_q[1][2:0]};
                doStop_q <= rep_q[1][rdim_pkg::BIT_STOP];
                sh_q <= rep_q[2];
                st_q <= rep_q[1][rdim_pkg::BIT_START] ? RDIM_START : RDIM_NEXT;
              end
            end else if (on_q && rep_q[0] == rdim_pkg::ID_READ
                         && rep_q[1] != 8'h00 && rep_q[1] <= 8'(rdim_pkg::RD_MAX)) begin
              isRead_q <= 1'b1;
              cmdPhase_q <= 1'b1;
              cnt_q <= rep_q[1][5:0];
              doStop_q <= 1'b1;
              sh_q <= rep_q[2];
              st_q <= RDIM_START;
            end
          end
        end
        RDIM_START: if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: begin
              sdaDrv_q <= 1'b1;
              sclDrv_q <= 1'b1;
            end
            2'h1: sdaDrv_q <= 1'b0;
            2'h2: sclDrv_q <= 1'b0;
            default: begin
              // Writes fetch byte 0 via NEXT so a zero count shifts nothing
              bit_q <= 3'h7;
              st_q <= isRead_q ? RDIM_BIT : RDIM_NEXT;
            end
          endcase
        end
        RDIM_BIT, RDIM_ACK, RDIM_RBIT, RDIM_RACK: if (stretchOut) begin
          err_q <= 1'b1;
          st_q <= RDIM_STOP;
          phase_q <= 2'h0;
        end else if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: begin
              if (st_q == RDIM_BIT)
                sdaDrv_q <= sh_q[bit_q];
              else if (st_q == RDIM_RACK)
                sdaDrv_q <= (idx_q == cnt_q - 6'h01);
              else
                sdaDrv_q <= 1'b1;
            end
            2'h1: sclDrv_q <= 1'b1;
            2'h2: if (st_q == RDIM_RBIT) sh_q[bit_q] <= sdaLvl_q;
            default: begin
              sclDrv_q <= 1'b0;
              // Index walks only in data states, so it rests at 7 through ack slots
              if (st_q == RDIM_BIT || st_q == RDIM_RBIT)
                bit_q <= bit_q - 3'h1;
              if (st_q == RDIM_BIT && bit_q == 3'h0)
                st_q <= RDIM_ACK;
              else if (st_q == RDIM_RBIT && bit_q == 3'h0) begin
                st_q <= RDIM_RACK;
                rd_q[idx_q] <= sh_q;
              end else if (st_q == RDIM_ACK) begin
                if (sdaLvl_q) begin
                  err_q <= 1'b1;
                  st_q <= RDIM_STOP;
                end else if (cmdPhase_q) begin
                  cmdPhase_q <= 1'b0;
                  idx_q <= 6'h00;
                  st_q <= RDIM_RBIT;
                end else begin
                  done_q <= done_q + 6'h01;
                  st_q <= RDIM_NEXT;
                end
              end else if (st_q == RDIM_RACK) begin
                idx_q <= idx_q + 6'h01;
                st_q <= (idx_q == cnt_q - 6'h01) ? RDIM_STOP : RDIM_RBIT;
              end
            end
          endcase
        end
        RDIM_NEXT: begin
          phase_q <= 2'h0;
          bit_q <= 3'h7;
          if (done_q < cnt_q) begin
            sh_q <= rep_q[6'h02 + done_q];
            st_q <= RDIM_BIT;
          end else
            st_q <= doStop_q ? RDIM_STOP : RDIM_REPLY;
        end
        RDIM_STOP: if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: sdaDrv_q <= 1'b0;
            2'h1: sclDrv_q <= 1'b1;
            2'h2: sdaDrv_q <= 1'b1;
            default: st_q <= RDIM_REPLY;
          endcase
        end
        RDIM_REPLY: begin
          // Reply image; output buffer rewritten without checking whether the host is still sending
          out_q[0] <= isRead_q ? rdim_pkg::ID_READ : rdim_pkg::ID_WRITE;
          out_q[1] <= isRead_q ? {err_q, 1'b0, (err_q ? 6'h00 : cnt_q)}
                               : {err_q, 4'h0, done_q[2:0]};
          idx_q <= 6'h02;
          st_q <= RDIM_SEND;
        end
        RDIM_SEND: begin
          out_q[idx_q] <= (isRead_q && !err_q && (idx_q - 6'h02) < cnt_q) ? rd_q[idx_q - 6'h02] : 8'h00;
          idx_q <= idx_q + 6'h01;
          if (idx_q == 6'h3f) begin
            rspTgl_q <= ~rspTgl_q;
            st_q <= RDIM_IDLE;
          end
        end
        default: st_q <= RDIM_IDLE;
      endcase
    end
  end

  // Pins: own the bus while enabled, else hand back to the port writes
  assign masterOn = on_q;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = on_q ? sclDrv_q : portWrite[1];
  assign sdaOe = on_q ? sdaDrv_q : portWrite[0];
endmodule
`default_nettype wire

// ==== test/rdim_checker.sv ====
// Purpose: Port assertions for rdim_master
// Assumes: Pin enables active low, replies of 64 bytes
// Notes: Reply byte count is kept on hostClk
`timescale 1ns/1ps
`default_nettype none
module rdim_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hostClk,
  input wire logic hostRstn,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [1:0] portWrite,
  input wire logic masterOn,
  input wire logic sclOe,
  input wire logic sdaOe
);
  logic [6:0] cnt_q;
  logic [7:0] id_q;
  always_ff @(posedge hostClk) begin
    if (!hostRstn || !txValid) begin
      cnt_q <= 7'h00;
    end else if (txReady) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
  always_ff @(posedge hostClk) begin
    if (txValid && txReady && cnt_q == 7'h00) begin
      id_q <= txByte;
    end
  end
  AST_REPLY_LEN: assert property (@(posedge hostClk) disable iff (!hostRstn) $fell(txValid) |-> cnt_q == 7'h40)
    else $error("reply not 64 bytes");
  AST_REPLY_CAP: assert property (@(posedge hostClk) disable iff (!hostRstn) txValid |-> cnt_q < 7'h40)
    else $error("reply longer than 64 bytes");
  AST_TX_HOLD: assert property (@(posedge hostClk) disable iff (!hostRstn)
    txValid && !txReady |=> txValid && $stable(txByte))
    else $error("reply byte dropped while stalled");
  AST_REPLY_ID: assert property (@(posedge hostClk) disable iff (!hostRstn)
    txValid && cnt_q == 7'h00 |-> txByte == 8'h02 || txByte == 8'h03)
    else $error("bad reply id");
  AST_WRITE_FLAGS: assert property (@(posedge hostClk) disable iff (!hostRstn)
    txValid && cnt_q == 7'h01 && id_q == 8'h02 |-> txByte[6:3] == 4'h0 && txByte[2:0] <= 3'h6)
    else $error("bad write ack flags");
  AST_READ_FLAGS: assert property (@(posedge hostClk) disable iff (!hostRstn)
    txValid && cnt_q == 7'h01 && id_q == 8'h03 |-> !txByte[6] && txByte[5:0] <= 6'h3e && (!txByte[7] || txByte[5:0] == 6'h00))
    else $error("bad read flags");
  AST_ENABLE_HIGH: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(masterOn) |-> ##[0:4] (sclOe && sdaOe))
    else $error("pins not released on enable");
  AST_PORT_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rstn)
    !masterOn && !$past(masterOn, 2) && $stable(portWrite) |-> {sclOe, sdaOe} == portWrite)
    else $error("pins ignore port value");
endmodule
bind rdim_master rdim_checker u_rdim_checker (.ref_clk, .rstn, .hostClk, .hostRstn, .txByte, .txValid,
  .txReady, .portWrite, .masterOn, .sclOe, .sdaOe);
`default_nettype wire

// ==== test/rdim_slave_model.sv ====
// Purpose: Two-wire slave for the bench
// Assumes: Pull-ups on both lines, no clock stretching
// Notes: First byte after start is the command; rdMode picks read
`timescale 1ns/1ps
`default_nettype none
module rdim_slave_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic rdMode,
  input wire logic [7:0] nackVal,
  input wire logic [7:0] rdData,
  output logic sclIn,
  output logic sdaIn
);
  logic scl_q, sda_q, drv_q, past_q, quiet_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  assign sclIn = sclOe;
  assign sdaIn = sdaOe & drv_q;
  always_ff @(posedge clk) begin
    scl_q <= sclIn;
    sda_q <= sdaIn;
    if (!rstn) begin
      drv_q <= 1'b1;
      cnt_q <= 4'h0;
      past_q <= 1'b0;
      quiet_q <= 1'b0;
    end else if (scl_q && sclIn && sda_q && !sdaIn) begin
      cnt_q <= 4'h0;
      past_q <= 1'b0;
      quiet_q <= 1'b0;
    end else if (!scl_q && sclIn) begin
      if (cnt_q == 4'h8) begin
        cnt_q <= 4'h0;
        past_q <= 1'b1;
        quiet_q <= rdMode && past_q && sdaIn;
      end else begin
        cnt_q <= cnt_q + 4'h1;
        sr_q <= {sr_q[6:0], sdaIn};
      end
    end else if (scl_q && !sclIn) begin
      if (cnt_q == 4'h8) begin
        drv_q <= (rdMode && past_q) || sr_q == nackVal;
      end else if (rdMode && past_q && !quiet_q) begin
        drv_q <= rdData[3'h7 - cnt_q[2:0]];
      end else begin
        drv_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/test_rdim_master.sv ====
// Purpose: Self-checking bench for rdim_master
// Assumes: hostClk 32 ns, ref_clk 5 ns
// Notes: Bus runs at 100 kHz, so few transfers fit
`timescale 1ns/1ps
`default_nettype none
module test_rdim_master;
  logic ref_clk = 1'b0, hostClk = 1'b0, rstn = 1'b0, hostRstn = 1'b0;
  logic rxValid = 1'b0, txReady = 1'b0, rdMode = 1'b0;
  logic [7:0] rxByte = 8'h00, nackVal = 8'h00, rdData = 8'h00, dat;
  logic [1:0] portWrite = 2'b11;
  logic [7:0] txByte;
  logic txValid, masterOn, sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe;
  logic [7:0] rep [64];
  logic [7:0] got [64];
  logic [31:0] seed = 32'h00015ca5;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  rdim_master u_rdim_master (.ref_clk, .rstn, .hostClk, .hostRstn, .rxByte, .rxValid, .txByte, .txValid,
    .txReady, .portWrite, .masterOn, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe);
  rdim_slave_model u_rdim_slave_model (.clk(ref_clk), .rstn, .sclOe, .sdaOe, .rdMode, .nackVal, .rdData,
    .sclIn, .sdaIn);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #3.7;
    forever #16 hostClk = ~hostClk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] flags(input logic err, input logic [5:0] n);
    return {err, 1'b0, n};
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Write reports carry random bytes past the count: the master must not care
  task automatic send(input logic [7:0] id, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    for (int i = 4; i < 64; i++) rep[i] = (id == 8'h02) ? rnd() : 8'h00;
    rep[0] = id;
    rep[1] = b1;
    rep[2] = b2;
    rep[3] = b3;
    for (int i = 0; i < 64; i++) begin
      @(posedge hostClk);
      #1;
      rxByte = rep[i];
      rxValid = 1'b1;
    end
    @(posedge hostClk);
    #1;
    rxValid = 1'b0;
  endtask
  task automatic chkRep(input logic [7:0] id, input logic [7:0] fl, input logic [7:0] d);
    int n;
    int w;
    n = 0;
    w = 0;
    while (n < 64 && w < 9000) begin
      @(posedge hostClk);
      if (txValid === 1'b1 && txReady === 1'b1) begin
        got[n] = txByte;
        n++;
      end
      w++;
      #1;
      txReady = rnd() > 8'h50;
    end
    chk("reply length", n[7:0], 8'h40);
    chk("reply id", got[0], id);
    chk("reply flags", got[1], fl);
    for (int i = 2; i < 64; i++) chk("reply body", got[i], (i == 2) ? d : 8'h00);
  endtask
  task automatic waitOn(input logic exp);
    for (int w = 0; w < 300 && masterOn !== exp; w++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    chk("enable state", {7'h00, masterOn}, {7'h00, exp});
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge hostClk);
    #1;
    rstn = 1'b1;
    hostRstn = 1'b1;
    portWrite = 2'b01;
    repeat (6) @(posedge ref_clk);
    chk("port pins", {6'h00, sclOe, sdaOe}, 8'h01);
    chk("pin levels", {6'h00, sclOut, sdaOut}, 8'h00);
    #1;
    portWrite = 2'b00;
    send(rdim_pkg::ID_ENABLE, rdim_pkg::EN_ON, rnd(), 8'h00);
    waitOn(1'b1);
    chk("pins on enable", {6'h00, sclOe, sdaOe}, 8'h03);
    send(rdim_pkg::ID_WRITE, 8'hc7, rnd(), rnd());
    for (int w = 0; w < 300; w++) begin
      @(posedge hostClk);
      chk("refused write", {6'h00, txValid, sdaIn}, 8'h01);
    end
    nackVal = rnd();
    dat = nackVal ^ (rnd() | 8'h01);
    // Split write: start-only chunk, then a stop-only chunk the slave refuses
    send(rdim_pkg::ID_WRITE, 8'h81, dat, rnd());
    chkRep(rdim_pkg::ID_WRITE, flags(1'b0, 6'h01), 8'h00);
    send(rdim_pkg::ID_WRITE, 8'h41, nackVal, rnd());
    chkRep(rdim_pkg::ID_WRITE, flags(1'b1, 6'h00), 8'h00);
    rdMode = 1'b1;
    rdData = rnd();
    send(rdim_pkg::ID_READ, 8'h01, dat, 8'h00);
    chkRep(rdim_pkg::ID_READ, flags(1'b0, 6'h01), rdData);
    rdMode = 1'b0;
    portWrite = 2'b11;
    send(rdim_pkg::ID_ENABLE, rdim_pkg::EN_OFF, rnd(), 8'h00);
    waitOn(1'b0);
    #1;
    portWrite = 2'b10;
    repeat (6) @(posedge ref_clk);
    chk("pins after disable", {6'h00, sclOe, sdaOe}, 8'h02);
    complete_run();
  end
endmodule
`default_nettype wire
